// ===== ddi_pkg.sv
// Package of constants and types for the display DRAM interface
package ddi_pkg;
  // Widths of memory and host paths
  localparam int DDI_ADDR_W = 9;
  localparam int DDI_DATA_W = 16;
  localparam int DDI_MAPS = 4;
  localparam int DDI_HADDR_W = 18;
  // Write FIFO depth
  localparam int DDI_FIFO_DEPTH = 4;
  // Row and column halves of an 18-bit word address
  localparam int DDI_ROW_LSB = 9;
  localparam int DDI_COL_LSB = 0;
  // Strobe timing in cycles of the 100 MHz clock
  localparam int DDI_CLK_PERIOD_NS = 10;
  localparam int DDI_TRP_NS = 30;
  localparam int DDI_TRP_CYC =
    (DDI_TRP_NS + DDI_CLK_PERIOD_NS - 1) / DDI_CLK_PERIOD_NS;
  localparam int DDI_TRAS_NS = 60;
  localparam int DDI_TRAS_CYC =
    (DDI_TRAS_NS + DDI_CLK_PERIOD_NS - 1) / DDI_CLK_PERIOD_NS;
  // Refresh interval: 15.6 us, longest time so rounded down
  localparam int DDI_REF_NS = 15600;
  localparam int DDI_REF_CYC = DDI_REF_NS / DDI_CLK_PERIOD_NS;
  // Strap capture delay after reset release
  localparam int DDI_STRAP_CYC = 2;
  // Reset values
  localparam logic [15:0] DDI_STRAP_RST = 16'h0000;
  localparam logic [8:0] DDI_ADDR_RST = 9'h000;
  // Access kinds chosen by the arbiter
  typedef enum logic [1:0] {
    DDI_ACC_NONE,
    DDI_ACC_REF,
    DDI_ACC_HOST,
    DDI_ACC_FETCH
  } ddi_acc_t;
endpackage

// ===== ddi_fifo.sv
// Small FIFO holding host write words for the DRAM sequencer
`timescale 1ns/1ps
module ddi_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PW = $clog2(DEPTH);
  // Storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  // Honest full and empty
  assign in_ready_o = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];
  // Pointer and count update
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
  // Storage write, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) mem[wr_ptr] <= in_data_i;
  end
endmodule

// ===== ddi_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ddi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Async in, synced out
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  // First stage feeds only the second
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule

// ===== ddi_top.sv
// Display DRAM interface: sequencer, host strobes, refresh, straps
`timescale 1ns/1ps
// Functional notes
// R1 - Nine-bit multiplexed DRAM address output
// R2 - Two row strobes, maps 0/1 and 2/3
// R3 - Two column strobes, maps 0/1 and 2/3
// R4 - Four write enables, one per map
// R5 - Two output enables, paired per map group
// R6 - Sixteen-bit bidirectional DRAM data bus
// R7 - Sample data-line straps at reset
// R8 - Host gives active-low refresh input
// R9 - Host I/O read strobe, ISA mode
// R10 - Host I/O write strobe, ISA mode
// R11 - Channel mode: read pin is status
// R12 - Channel mode: write pin is command
// R13 - Memory/IO select: high memory, low I/O; decoded only in channel mode, ISA mode ignores it
// R14 - Ready drops only for video memory
// R15 - Row before row strobe, column before column
// R16 - Periodic refresh, arbitrated with other accesses
module ddi_top
  import ddi_pkg::*;
#(
  parameter int REF_CYC = DDI_REF_CYC
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // Host bus pins
  input wire logic CHAN_MODE_I,
  input wire logic HOST_REFRESH_N_I,
  input wire logic IO_READ_N_I,
  input wire logic IO_WRITE_N_I,
  input wire logic MEM_IO_SEL_I,
  input wire logic VMEM_SEL_I,
  input wire logic MEM_WRITE_I,
  input wire logic MEM_REQ_I,
  input wire logic [17:0] HOST_ADDR_I,
  input wire logic [15:0] HOST_WDATA_I,
  input wire logic [3:0] HOST_MAP_MASK_I,
  output logic BUS_READY_OUT_O,
  output logic IO_RD_CYC_O,
  output logic IO_WR_CYC_O,
  output logic [15:0] HOST_RDATA_O,
  output logic HOST_RVALID_O,
  // Display fetch request (same clock)
  input wire logic FETCH_REQ_I,
  input wire logic [17:0] FETCH_ADDR_I,
  output logic FETCH_DONE_O,
  // DRAM pins
  output logic [8:0] DRAM_MUX_ADDR_O,
  output logic ROW_STROBE_MAPS_LOW_N_O,
  output logic ROW_STROBE_MAPS_HIGH_N_O,
  output logic COL_STROBE_MAPS_LOW_N_O,
  output logic COL_STROBE_MAPS_HIGH_N_O,
  output logic MAP0_WRITE_EN_N_O,
  output logic MAP1_WRITE_EN_N_O,
  output logic MAP2_WRITE_EN_N_O,
  output logic MAP3_WRITE_EN_N_O,
  output logic OUT_EN_MAPS_LOW_N_O,
  output logic OUT_EN_MAPS_HIGH_N_O,
  input wire logic [15:0] DRAM_DATA_BUS_I,
  output logic [15:0] DRAM_DATA_BUS_O,
  output logic DRAM_DATA_BUS_OE_O,
  // Configuration straps and write buffer ready
  output logic [15:0] STRAP_CFG_O,
  output logic FIFO_READY_O
);
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_ROW, ST_RAS, ST_COL, ST_CAS, ST_PRE
  } ddi_state_t;

  // Synchronised pin inputs; reset values are the idle pin levels
  logic [7:0] pins_s;
  logic [15:0] md_s;
  ddi_sync #(.WIDTH(8), .RST_VAL(8'h78)) u_sync_pins (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .d_i({CHAN_MODE_I, HOST_REFRESH_N_I, IO_READ_N_I, IO_WRITE_N_I,
          MEM_IO_SEL_I, VMEM_SEL_I, MEM_WRITE_I, MEM_REQ_I}),
    .q_o(pins_s)
  );
  ddi_sync #(.WIDTH(16), .RST_VAL(16'h0000)) u_sync_md (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .d_i(DRAM_DATA_BUS_I),
    .q_o(md_s)
  );
  wire chan_mode_s = pins_s[7];
  wire refresh_n_s = pins_s[6];
  wire io_rd_n_s = pins_s[5];
  wire io_wr_n_s = pins_s[4];
  wire mem_io_s = pins_s[3];
  wire vmem_s = pins_s[2];
  wire mem_wr_s = pins_s[1];
  wire mem_req_s = pins_s[0];

  // Host cycle decode; channel mode uses status and command pins
  logic cmd_n_d;
  wire cmd_rise = chan_mode_s && io_wr_n_s && !cmd_n_d; // [R12]
  wire isa_io_rd = !chan_mode_s && !io_rd_n_s; // [R9]
  wire isa_io_wr = !chan_mode_s && !io_wr_n_s; // [R10]
  wire chan_io = chan_mode_s && !io_wr_n_s && !mem_io_s; // [R12] [R13]
  wire chan_io_rd = chan_io && !io_rd_n_s; // [R11]
  wire chan_io_wr = chan_io && io_rd_n_s; // [R11]
  wire next_io_rd = isa_io_rd || chan_io_rd;
  wire next_io_wr = isa_io_wr || chan_io_wr;
  wire chan_mem_ok = !chan_mode_s || (mem_io_s && !io_wr_n_s); // [R13]
  wire host_mem = mem_req_s && vmem_s && chan_mem_ok;
  wire refresh_cyc = !refresh_n_s; // [R8]

  // Request edge so each host cycle is taken once
  logic host_busy;
  wire host_start = host_mem && !host_busy;

  // Write FIFO between host and sequencer
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [15:0] fifo_data;
  ddi_fifo #(.WIDTH(DDI_DATA_W), .DEPTH(DDI_FIFO_DEPTH)) u_wfifo (
    .clk_i(CLK_SYS_I),
    .rst_b_i(RST_B_I),
    .in_valid_i(host_start && mem_wr_s),
    .in_ready_o(fifo_in_ready),
    .in_data_i(HOST_WDATA_I),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  // Sequencer state and counters
  ddi_state_t state;
  ddi_state_t next_state;
  ddi_acc_t acc;
  logic [3:0] tcnt;
  logic [15:0] ref_cnt;
  logic ref_pend;
  logic host_pend;
  logic host_wr;
  logic [17:0] host_addr;
  logic [17:0] acc_addr;
  logic [3:0] acc_maps;
  logic acc_wr;
  logic [8:0] ref_row;

  // Arbitration: refresh first, then host, then fetch [R16]
  wire ref_due = ref_pend;
  wire host_due = host_pend && (!host_wr || fifo_out_valid);
  ddi_acc_t next_acc;
  assign next_acc = ref_due ? DDI_ACC_REF :
                    host_due ? DDI_ACC_HOST :
                    FETCH_REQ_I ? DDI_ACC_FETCH : DDI_ACC_NONE;
  wire tdone = (tcnt == 4'h0);
  assign fifo_pop = (state == ST_COL) && (acc == DDI_ACC_HOST) && acc_wr;

  // Next-state logic of the sequencer
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: if (next_acc != DDI_ACC_NONE) next_state = ST_ROW;
      ST_ROW: next_state = ST_RAS;
      ST_RAS: if (tdone) next_state = (acc == DDI_ACC_REF) ? ST_PRE : ST_COL;
      ST_COL: next_state = ST_CAS;
      ST_CAS: if (tdone) next_state = ST_PRE;
      ST_PRE: if (tdone) next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // Row address put out two cycles before row strobe [R15]
  wire [8:0] row_addr = (next_acc == DDI_ACC_REF) ? ref_row :
    (next_acc == DDI_ACC_HOST) ? host_addr[17:9] : FETCH_ADDR_I[17:9];
  wire [8:0] next_mux_addr =
    (state == ST_IDLE) ? row_addr :
    (state == ST_RAS && tdone) ? acc_addr[8:0] : DRAM_MUX_ADDR_O; // [R1]
  wire strobe_row = (state == ST_RAS) || (state == ST_COL) ||
                    (state == ST_CAS);
  wire strobe_col = (state == ST_CAS);
  wire lo_grp = (acc == DDI_ACC_REF) || (|acc_maps[1:0]);
  wire hi_grp = (acc == DDI_ACC_REF) || (|acc_maps[3:2]);

  // Sequencer, counters and latched access
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      state <= ST_IDLE;
      acc <= DDI_ACC_NONE;
      tcnt <= 4'h0;
      acc_addr <= 18'h00000;
      acc_maps <= 4'h0;
      acc_wr <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && next_acc != DDI_ACC_NONE) begin
        acc <= next_acc;
        acc_addr <= (next_acc == DDI_ACC_HOST) ? host_addr : FETCH_ADDR_I;
        acc_maps <= (next_acc == DDI_ACC_HOST) ? HOST_MAP_MASK_I : 4'hf;
        acc_wr <= (next_acc == DDI_ACC_HOST) && host_wr;
      end
      if (next_state != state) begin
        tcnt <= (next_state == ST_PRE) ? 4'(DDI_TRP_CYC - 1) :
                (next_state == ST_RAS) ? 4'(DDI_TRAS_CYC / 2 - 1) :
                (next_state == ST_CAS) ? 4'(DDI_TRAS_CYC / 2 - 1) : 4'h0;
      end else if (!tdone) begin
        tcnt <= tcnt - 4'h1;
      end
    end
  end

  // Refresh timer; host refresh cycles also request one [R8] [R16]
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ref_cnt <= 16'h0000;
      ref_pend <= 1'b0;
      ref_row <= DDI_ADDR_RST;
    end else begin
      ref_cnt <= (ref_cnt == 16'(REF_CYC - 1)) ? 16'h0000 : ref_cnt + 16'h1;
      if (ref_cnt == 16'(REF_CYC - 1) || refresh_cyc) ref_pend <= 1'b1;
      else if (state == ST_IDLE && next_acc == DDI_ACC_REF) ref_pend <= 1'b0;
      if (state == ST_PRE && tdone && acc == DDI_ACC_REF)
        ref_row <= ref_row + 9'h1;
    end
  end

  // Host request capture and ready; waits only on video memory [R14]
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      host_busy <= 1'b0;
      host_pend <= 1'b0;
      host_wr <= 1'b0;
      host_addr <= 18'h00000;
      BUS_READY_OUT_O <= 1'b1;
      cmd_n_d <= 1'b1;
    end else begin
      cmd_n_d <= io_wr_n_s;
      if (!host_mem || cmd_rise) host_busy <= 1'b0;
      else if (host_start && (!mem_wr_s || fifo_in_ready)) host_busy <= 1'b1;
      if (host_start && (!mem_wr_s || fifo_in_ready)) begin
        host_pend <= 1'b1;
        host_wr <= mem_wr_s;
        host_addr <= HOST_ADDR_I;
      end else if (state == ST_IDLE && next_acc == DDI_ACC_HOST) begin
        host_pend <= 1'b0;
      end
      BUS_READY_OUT_O <= !(host_mem && (host_pend || !host_busy)); // [R14]
    end
  end

  // DRAM pin drive, all registered [R1] [R2] [R3] [R4] [R5] [R6]
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      DRAM_MUX_ADDR_O <= DDI_ADDR_RST;
      ROW_STROBE_MAPS_LOW_N_O <= 1'b1;
      ROW_STROBE_MAPS_HIGH_N_O <= 1'b1;
      COL_STROBE_MAPS_LOW_N_O <= 1'b1;
      COL_STROBE_MAPS_HIGH_N_O <= 1'b1;
      {MAP3_WRITE_EN_N_O, MAP2_WRITE_EN_N_O} <= 2'h3;
      {MAP1_WRITE_EN_N_O, MAP0_WRITE_EN_N_O} <= 2'h3;
      OUT_EN_MAPS_LOW_N_O <= 1'b1;
      OUT_EN_MAPS_HIGH_N_O <= 1'b1;
      DRAM_DATA_BUS_O <= 16'h0000;
      DRAM_DATA_BUS_OE_O <= 1'b0;
    end else begin
      DRAM_MUX_ADDR_O <= next_mux_addr; // [R1] [R15]
      ROW_STROBE_MAPS_LOW_N_O <= !(strobe_row && lo_grp); // [R2]
      ROW_STROBE_MAPS_HIGH_N_O <= !(strobe_row && hi_grp); // [R2]
      COL_STROBE_MAPS_LOW_N_O <= !(strobe_col && lo_grp); // [R3]
      COL_STROBE_MAPS_HIGH_N_O <= !(strobe_col && hi_grp); // [R3]
      MAP0_WRITE_EN_N_O <= !(strobe_row && acc_wr && acc_maps[0]); // [R4]
      MAP1_WRITE_EN_N_O <= !(strobe_row && acc_wr && acc_maps[1]); // [R4]
      MAP2_WRITE_EN_N_O <= !(strobe_row && acc_wr && acc_maps[2]); // [R4]
      MAP3_WRITE_EN_N_O <= !(strobe_row && acc_wr && acc_maps[3]); // [R4]
      OUT_EN_MAPS_LOW_N_O <= !(strobe_col && !acc_wr && lo_grp &&
                               acc != DDI_ACC_REF); // [R5]
      OUT_EN_MAPS_HIGH_N_O <= !(strobe_col && !acc_wr && hi_grp &&
                                acc != DDI_ACC_REF); // [R5]
      if (fifo_pop) DRAM_DATA_BUS_O <= fifo_data; // [R6]
      DRAM_DATA_BUS_OE_O <= (state == ST_COL || state == ST_CAS) &&
                            acc_wr && next_state != ST_PRE; // [R6]
    end
  end

  // Read data return, straps and host cycle flags [R6] [R7]
  logic [2:0] strap_cnt; // Sync latency, then the strap window
  wire read_end = state == ST_CAS && tdone && !acc_wr && acc != DDI_ACC_REF;
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      HOST_RDATA_O <= 16'h0000;
      HOST_RVALID_O <= 1'b0;
      FETCH_DONE_O <= 1'b0;
      STRAP_CFG_O <= DDI_STRAP_RST;
      strap_cnt <= 3'h0;
      IO_RD_CYC_O <= 1'b0;
      IO_WR_CYC_O <= 1'b0;
      FIFO_READY_O <= 1'b0;
    end else begin
      HOST_RVALID_O <= read_end && acc == DDI_ACC_HOST;
      FETCH_DONE_O <= state == ST_PRE && tdone && acc == DDI_ACC_FETCH;
      if (read_end) HOST_RDATA_O <= DRAM_DATA_BUS_I; // [R6]
      if (strap_cnt != 3'(DDI_STRAP_CYC + 2)) begin // Plus sync latency
        strap_cnt <= strap_cnt + 3'h1;
        STRAP_CFG_O <= md_s; // [R7]
      end
      IO_RD_CYC_O <= next_io_rd; // [R9] [R11]
      IO_WR_CYC_O <= next_io_wr; // [R10] [R12]
      FIFO_READY_O <= fifo_in_ready;
    end
  end

  // Row strobe must precede column strobe of the low group
  row_first_a: assert property (@(posedge CLK_SYS_I) // [R15]
    disable iff (!RST_B_I)
    $fell(COL_STROBE_MAPS_LOW_N_O) |-> !ROW_STROBE_MAPS_LOW_N_O)
    else $error("column strobe without row strobe");
  // Row address must already stand when the row strobe falls
  row_addr_hold_a: assert property (@(posedge CLK_SYS_I) // [R15]
    disable iff (!RST_B_I)
    $fell(ROW_STROBE_MAPS_LOW_N_O) |-> $stable(DRAM_MUX_ADDR_O))
    else $error("row address moved at row strobe");
  ready_video_a: assert property (@(posedge CLK_SYS_I) // [R14]
    disable iff (!RST_B_I) !BUS_READY_OUT_O |-> $past(host_mem))
    else $error("ready dropped outside video access");
  refresh_served_a: assert property (@(posedge CLK_SYS_I) // [R16]
    disable iff (!RST_B_I)
    $rose(ref_pend) |-> ##[1:40] !ROW_STROBE_MAPS_HIGH_N_O)
    else $error("refresh not served in time");
  we_only_write_a: assert property (@(posedge CLK_SYS_I) // [R4]
    disable iff (!RST_B_I)
    !MAP0_WRITE_EN_N_O |-> !ROW_STROBE_MAPS_LOW_N_O)
    else $error("write enable outside row cycle");
  oe_no_drive_a: assert property (@(posedge CLK_SYS_I) // [R5]
    disable iff (!RST_B_I) !OUT_EN_MAPS_LOW_N_O |-> !DRAM_DATA_BUS_OE_O)
    else $error("bus driven during DRAM read");
endmodule

// ===== ddi_dram_model.sv
// Behavioural display DRAM pair with strap resistors on the data lines
`timescale 1ns/1ps
module ddi_dram_model #(
  parameter logic [15:0] STRAP = 16'h5a3c
) (
  // Clock
  input wire logic clk_i,
  // Strobes, low group in bit 0
  input wire logic [1:0] ras_n_i,
  input wire logic [1:0] cas_n_i,
  input wire logic [3:0] we_n_i,
  input wire logic [1:0] oe_n_i,
  input wire logic [8:0] addr_i,
  // Controller side of the data lines
  input wire logic [15:0] dq_i,
  input wire logic dq_oe_i,
  // Resolved data lines
  output logic [15:0] dq_o,
  // Row and column of the last column access, refreshes seen
  output logic [8:0] row_o,
  output logic [8:0] col_o,
  output int ref_cnt_o
);
  logic [15:0] mem [0:1048575]; // Words indexed by map, row, column
  logic [8:0] addr_q = 9'h000; // Address present the cycle before
  logic [8:0] row = 9'h000; // Row latched at row strobe fall
  logic [1:0] ras_q = 2'h3; // Row strobes one cycle ago
  logic [1:0] cas_q = 2'h3; // Column strobes one cycle ago
  logic cas_seen = 1'b0; // Column strobe seen since row strobe fell
  logic [15:0] rd; // Word the enabled group puts out
  initial ref_cnt_o = 0;
  initial row_o = 9'h000;
  initial col_o = 9'h000;
  // Word of the enabled group, map 0 or map 2 as reader
  assign rd = mem[{!oe_n_i[0] ? 2'd0 : 2'd2, row_o, col_o}];
  // Group with output enable and column strobe low drives, else pulls
  always @* begin
    if (dq_oe_i) begin
      dq_o = dq_i;
    end else if ((~oe_n_i & ~cas_n_i) != 2'h0) begin
      dq_o = rd;
    end else begin
      dq_o = STRAP; // Resistor levels when released
    end
  end
  // Latch row and column from the address held before each strobe
  always @(posedge clk_i) begin
    addr_q <= addr_i;
    ras_q <= ras_n_i;
    cas_q <= cas_n_i;
    if ((ras_q & ~ras_n_i) != 2'h0) begin
      row <= addr_q;
      cas_seen <= 1'b0;
    end
    if ((cas_q & ~cas_n_i) != 2'h0) begin
      row_o <= row;
      col_o <= addr_q;
      cas_seen <= 1'b1;
    end
    // Row strobe rising with no column strobe counts as refresh
    if ((~ras_q & ras_n_i) != 2'h0 && !cas_seen) begin
      ref_cnt_o <= ref_cnt_o + 1;
    end
    // Store on second column strobe cycle, per map enable
    for (int m = 0; m < 4; m++) begin
      if (!we_n_i[m] && !cas_n_i[m/2] && !cas_q[m/2] && dq_oe_i) begin
        mem[{m[1:0], row_o, col_o}] <= dq_i;
      end
    end
  end
endmodule

// ===== testbench.sv
// Self-checking bench for the display DRAM interface
`timescale 1ns/1ps
module testbench;
  import ddi_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0; // Clock and reset
  logic chan = 1'b0, ref_n = 1'b1, io_rd_n = 1'b1, io_wr_n = 1'b1;
  logic mio = 1'b1, vmem = 1'b0, mwr = 1'b0, mreq = 1'b0, freq = 1'b0;
  logic [17:0] haddr = 18'h00000, faddr = 18'h00000; // Host, fetch
  logic [15:0] hwdata = 16'h0000, rdata, dq_o, dq_in, strap;
  logic [3:0] hmask = 4'h0, we_n, we_q = 4'hf; // Map enables
  logic [1:0] ras_n, cas_n, oe_n; // Strobes, low group in bit 0
  logic [8:0] maddr, row, col; // DRAM address, model latches
  logic rdy, io_rd, io_wr, rvalid, fdone, dq_oe, fifo_rdy, rdy_low;
  int errors = 0, n_compared = 0, ref_cnt, we_cnt[4], r0;
  always #5 clk = ~clk;
  ddi_top #(.REF_CYC(40)) u_dut (.CLK_SYS_I(clk), .RST_B_I(rst_b),
    .CHAN_MODE_I(chan), .HOST_REFRESH_N_I(ref_n), .IO_READ_N_I(io_rd_n),
    .IO_WRITE_N_I(io_wr_n), .MEM_IO_SEL_I(mio), .VMEM_SEL_I(vmem),
    .MEM_WRITE_I(mwr), .MEM_REQ_I(mreq), .HOST_ADDR_I(haddr),
    .HOST_WDATA_I(hwdata), .HOST_MAP_MASK_I(hmask),
    .BUS_READY_OUT_O(rdy), .IO_RD_CYC_O(io_rd), .IO_WR_CYC_O(io_wr),
    .HOST_RDATA_O(rdata), .HOST_RVALID_O(rvalid), .FETCH_REQ_I(freq),
    .FETCH_ADDR_I(faddr), .FETCH_DONE_O(fdone), .DRAM_MUX_ADDR_O(maddr),
    .ROW_STROBE_MAPS_LOW_N_O(ras_n[0]), .ROW_STROBE_MAPS_HIGH_N_O(ras_n[1]),
    .COL_STROBE_MAPS_LOW_N_O(cas_n[0]), .COL_STROBE_MAPS_HIGH_N_O(cas_n[1]),
    .MAP0_WRITE_EN_N_O(we_n[0]), .MAP1_WRITE_EN_N_O(we_n[1]),
    .MAP2_WRITE_EN_N_O(we_n[2]), .MAP3_WRITE_EN_N_O(we_n[3]),
    .OUT_EN_MAPS_LOW_N_O(oe_n[0]), .OUT_EN_MAPS_HIGH_N_O(oe_n[1]),
    .DRAM_DATA_BUS_I(dq_in), .DRAM_DATA_BUS_O(dq_o),
    .DRAM_DATA_BUS_OE_O(dq_oe), .STRAP_CFG_O(strap),
    .FIFO_READY_O(fifo_rdy));
  ddi_dram_model #(.STRAP(16'h5a3c)) u_mem (.clk_i(clk), .ras_n_i(ras_n),
    .cas_n_i(cas_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(maddr),
    .dq_i(dq_o), .dq_oe_i(dq_oe), .dq_o(dq_in), .row_o(row), .col_o(col),
    .ref_cnt_o(ref_cnt));
  // Watch for wait states and count write enable pulses per map
  always @(posedge clk) begin
    we_q <= we_n;
    if (rdy === 1'b0) rdy_low <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      if (we_q[m] && !we_n[m]) we_cnt[m]++;
    end
  end
  // One comparison of a value against its expectation
  task automatic chk_val(input logic [17:0] got, input logic [17:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Print the verdict and stop
  task automatic end_sim;
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One host memory cycle; waits for grant or read data
  task automatic host_mem(input logic wr, input logic [17:0] a,
    input logic [15:0] d, input logic [3:0] m, output logic [15:0] q);
    int t;
    t = 0;
    @(posedge clk);
    rdy_low = 1'b0;
    {mreq, vmem, mwr, mio} <= {3'b110 | {2'b0, wr}, 1'b1};
    {haddr, hwdata, hmask} <= {a, d, m};
    io_wr_n <= !chan; // Command low in channel mode
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (!(wr ? (rdy_low && rdy === 1'b1) : rvalid === 1'b1) && t < 80);
    q = rdata;
    chk_val(t < 80, 1'b1);
    chk_val(rdy_low, 1'b1);
    @(posedge clk);
    {mreq, vmem} <= 2'b00;
    io_wr_n <= 1'b1;
    repeat (20) @(posedge clk);
  endtask
  // An I/O cycle: decoded level expected, no wait state
  task automatic io_cyc(input logic rn, wn, s, er, ew);
    @(posedge clk);
    rdy_low = 1'b0;
    {io_rd_n, io_wr_n, mio} <= {rn, wn, s};
    repeat (6) @(posedge clk);
    #1;
    chk_val({io_rd, io_wr}, {er, ew});
    chk_val(rdy_low, 1'b0);
    @(posedge clk);
    {io_rd_n, io_wr_n, mio} <= 3'b111;
    repeat (6) @(posedge clk);
  endtask
  // Idle levels in reset and straps captured after release
  task automatic t_reset;
    repeat (12) @(posedge clk);
    #1;
    chk_val({ras_n, cas_n, we_n, oe_n}, 10'h3ff);
    chk_val({dq_oe, rdy}, 2'b01);
    @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk_val(strap, 16'h5a3c);
    chk_val(fifo_rdy, 1'b1); // Empty write buffer accepts
  endtask
  // Write and read back in the map groups of mask m, check per map enables
  task automatic t_mem(input logic [17:0] a, input logic [3:0] m,
    input logic [15:0] d);
    int w[4];
    logic [15:0] q;
    w = we_cnt;
    host_mem(1'b1, a, d, m, q);
    chk_val({row, col}, a);
    for (int i = 0; i < 4; i++) chk_val(we_cnt[i] - w[i], m[i]);
    host_mem(1'b0, a, 16'h0000, m, q);
    chk_val(q, d);
  endtask
  // Refresh from the bus pin and the periodic timer
  task automatic t_refresh;
    r0 = ref_cnt;
    @(posedge clk);
    ref_n <= 1'b0;
    repeat (3) @(posedge clk);
    ref_n <= 1'b1;
    repeat (30) @(posedge clk);
    chk_val(ref_cnt > r0, 1'b1);
    r0 = ref_cnt;
    repeat (400) @(posedge clk);
    chk_val(ref_cnt - r0 >= 9 && ref_cnt - r0 <= 11, 1'b1);
  endtask
  // Display fetch granted between host cycles
  task automatic t_fetch;
    int t;
    t = 0;
    @(posedge clk);
    {freq, faddr} <= {1'b1, 18'h2a155};
    do begin
      @(posedge clk);
      #1;
      t++;
    end while (fdone !== 1'b1 && t < 80);
    chk_val(t < 80, 1'b1);
    @(posedge clk);
    freq <= 1'b0;
    repeat (20) @(posedge clk);
    chk_val({row, col}, 18'h2a155);
  endtask
  initial begin
    t_reset();
    t_mem(18'h12345, 4'h1, 16'ha5c3);
    t_mem(18'h3fe01, 4'h4, 16'h3c96);
    t_mem(18'h001ff, 4'h5, 16'hf00d);
    io_cyc(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    io_cyc(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
    t_refresh();
    t_fetch();
    chan <= 1'b1;
    t_mem(18'h2b0c4, 4'h4, 16'h7e81);
    io_cyc(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    end_sim();
  end
  // Cut a hang short
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule
